// ===== hw/fml_pkg.sv
// shared constants and types of the mailbox/loopback/offset block
package fml_pkg;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MAIL2  = 8'h08;
    localparam logic [7:0] REG_MAIL1  = 8'h0c;
    localparam logic [7:0] REG_F1_SEC = 8'h10;
    localparam logic [7:0] REG_F1_FST = 8'h14;
    localparam logic [7:0] REG_F2_SEC = 8'h18;
    localparam logic [7:0] REG_F2_FST = 8'h1c;
    // ----------------------------------------
    // field positions, reset values and default sizes
    // ----------------------------------------
    localparam int         CTRL_LOOP_N_BIT = 0;
    localparam logic       CTRL_LOOP_N_RST = 1'b1;
    localparam int         OFS_W_DEF       = 11;
    localparam int         FIFO_W_DEF      = 36;
    localparam int         FIFO_D_DEF      = 16;
    // ----------------------------------------
    // offset method codes on the three selects and preset offset values
    // ----------------------------------------
    localparam logic [2:0] SEL_PRE8    = 3'h0;
    localparam logic [2:0] SEL_PRE16   = 3'h1;
    localparam logic [2:0] SEL_PRE64   = 3'h2;
    localparam logic [2:0] SEL_PRE256  = 3'h3;
    localparam logic [2:0] SEL_PRE1024 = 3'h4;
    localparam logic [2:0] SEL_SERIAL  = 3'h5;
    localparam logic [2:0] SEL_PARAL   = 3'h6;
    localparam int PRE8    = 8;
    localparam int PRE16   = 16;
    localparam int PRE64   = 64;
    localparam int PRE256  = 256;
    localparam int PRE1024 = 1024;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_CAPTURE = 2'b01,
        ST_RUN     = 2'b10
    } fml_cfg_e;
    typedef struct packed {
        logic [5:0] ser_count;
        logic [2:0] method;
        logic       loop_act;
        logic       fifo1_in_ready;
        logic       fifo1_out_valid;
        logic       second_full_n;
        logic       first_full_n;
    } fml_status_s;
endpackage

// ===== hw/fml_top.sv
// mailbox, port a loopback, serial offset loader and fifo1 buffer
// ----------------------------------------
// Overview of operation
// RQ1: method caught from selects after reset release
// RQ2: serial enable active low, sampled each clock
// RQ3: enabled clock shifts serial bit into chain
// RQ4: host gives 44, 48 or 52 bits
// RQ5: first bit fifo1 second msb, last fifo2 first lsb
// RQ6: chain order f1 second, f1 first, f2 second, f2 first
// RQ7: loopback routes fifo2 words into fifo1 input
// RQ8: loop select low and port a enable high
// RQ9: port a mail select picks mailbox over fifo
// RQ10: port a shows mail2 or fifo2 output word
// RQ11: port b mail select picks mailbox over fifo1
// RQ12: port b shows mail1 or fifo1 output word
// RQ13: port b mail read empties first mailbox
// RQ14: port a mail read empties second mailbox
// ----------------------------------------
`timescale 1ns/10ps

// ----------------------------------------
// fifo with registered ready and valid
// ----------------------------------------
module fml_fifo
    import fml_pkg::*;
#(
    parameter int W = FIFO_W_DEF,
    parameter int D = FIFO_D_DEF
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic [AW:0]   next_count;
    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data   = mem[rd_ptr];

    always_ff @(posedge ref_clk) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wr_ptr    <= wr_ptr + AW'(push);
            rd_ptr    <= rd_ptr + AW'(pop);
            count     <= next_count;
            in_ready  <= next_count != FULL;
            out_valid <= next_count != '0;
        end
    end
endmodule

// ----------------------------------------
// top level
// ----------------------------------------
module fml_top
    import fml_pkg::*;
#(
    parameter int OFS_W = OFS_W_DEF,
    parameter int FW    = FIFO_W_DEF,
    parameter int FD    = FIFO_D_DEF
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst,
    // ahb-lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic          hready,
    input  wire logic [31:0]   hwdata,
    output logic [31:0]        hrdata,
    output logic               hreadyout,
    output logic               hresp,
    // offset selects and serial load
    input  wire logic          offset_sel0_serial_din,
    input  wire logic          offset_sel1_serial_en_n,
    input  wire logic          offset_sel_bit2,
    // port a
    input  wire logic          port_a_access_en,
    input  wire logic          port_a_mail_sel,
    input  wire logic          port_a_wr,
    input  wire logic [FW-1:0] port_a_din,
    output logic               port_a_wr_ready,
    input  wire logic          port_a_rd,
    output logic [FW-1:0]      port_a_bus,
    // fifo2 output register
    input  wire logic          fifo2_valid,
    input  wire logic [FW-1:0] fifo2_dout,
    output logic               fifo2_take,
    // port b
    input  wire logic          port_b_rd,
    input  wire logic          port_b_mail_sel,
    output logic [17:0]        port_b_bus,
    output logic               port_b_valid,
    // mailbox flags
    output logic               first_mail_full_n,
    output logic               second_mail_full_n
);
    localparam int CH = 4 * OFS_W;
    // ----------------------------------------
    // state
    // ----------------------------------------
    fml_cfg_e      cfg;
    logic [2:0]    method;
    logic [CH-1:0] chain;
    logic [5:0]    ser_count;
    logic          loop_n;
    logic [FW-1:0] mail1;
    logic [FW-1:0] mail2;
    logic          a_act;
    logic          a_wr_q;
    logic [7:0]    a_addr;
    fml_status_s   status;

    function automatic logic [OFS_W-1:0] preset(input logic [2:0] c);
        unique case (c)
            SEL_PRE8:    preset = OFS_W'(PRE8);
            SEL_PRE16:   preset = OFS_W'(PRE16);
            SEL_PRE64:   preset = OFS_W'(PRE64);
            SEL_PRE256:  preset = OFS_W'(PRE256);
            SEL_PRE1024: preset = OFS_W'(PRE1024);
            default:     preset = '0;
        endcase
    endfunction

    function automatic logic [31:0] ofs_word(input logic [OFS_W-1:0] v);
        ofs_word = 32'(v);
    endfunction

    // ----------------------------------------
    // offset loading
    // ----------------------------------------
    wire [2:0] sel_pins = {offset_sel_bit2, offset_sel1_serial_en_n,
                           offset_sel0_serial_din};
    wire ser_shift = (cfg == ST_RUN) && (method == SEL_SERIAL)
                     && !offset_sel1_serial_en_n       // RQ2
                     && (ser_count < 6'(CH));           // RQ4
    wire [OFS_W-1:0] f1_sec = chain[4*OFS_W-1:3*OFS_W]; // RQ6
    wire [OFS_W-1:0] f1_fst = chain[3*OFS_W-1:2*OFS_W];
    wire [OFS_W-1:0] f2_sec = chain[2*OFS_W-1:OFS_W];
    wire [OFS_W-1:0] f2_fst = chain[OFS_W-1:0];

    // selects are caught on the first edge after release, not by reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg    <= ST_CAPTURE;
            method <= SEL_PRE8;
        end else if (cfg == ST_CAPTURE) begin
            cfg    <= ST_RUN;
            method <= sel_pins;                          // RQ1
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chain     <= '0;
            ser_count <= '0;
        end else if (cfg == ST_CAPTURE) begin
            chain     <= {4{preset(sel_pins)}};          // RQ1
            ser_count <= '0;
        end else if (ser_shift) begin
            // msb first: first bit ends at top of fifo1 second
            chain     <= {chain[CH-2:0],
                          offset_sel0_serial_din};       // RQ3 RQ5
            ser_count <= ser_count + 6'h01;
        end
    end

    // ----------------------------------------
    // loopback and fifo1 path
    // ----------------------------------------
    wire loop_act = !loop_n && port_a_access_en;         // RQ8
    // take is registered: the word it flags is still shown, already used
    wire f2_avail = fifo2_valid && !fifo2_take;
    wire f1_in_ready;
    wire f1_out_valid;
    wire [FW-1:0] f1_out_data;
    wire a_fifo_wr = port_a_access_en && port_a_wr
                     && !port_a_mail_sel;                // RQ9
    wire f1_in_valid = loop_act ? f2_avail : a_fifo_wr;
    wire [FW-1:0] f1_in_data = loop_act ? fifo2_dout
                                        : port_a_din;    // RQ7
    wire a_fifo_rd = port_a_access_en && port_a_rd
                     && !port_a_mail_sel;
    // loopback drains fifo2 only as fast as fifo1 accepts
    wire f2_take = loop_act ? (f2_avail && f1_in_ready)
                            : (a_fifo_rd && f2_avail);
    wire b_fifo_rd = port_b_rd && !port_b_mail_sel;      // RQ11

    fml_fifo #(
        .W (FW),
        .D (FD)
    ) u_fifo1 (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (f1_in_valid),
        .in_data   (f1_in_data),
        .in_ready  (f1_in_ready),
        .out_valid (f1_out_valid),
        .out_data  (f1_out_data),
        .out_ready (b_fifo_rd)
    );

    // ----------------------------------------
    // mailboxes
    // ----------------------------------------
    wire a_mail_wr = port_a_access_en && port_a_wr && port_a_mail_sel
                     && first_mail_full_n && !loop_act;  // RQ9 RQ13
    wire a_mail_rd = port_a_access_en && port_a_rd
                     && port_a_mail_sel;                 // RQ14
    wire b_mail_rd = port_b_rd && port_b_mail_sel;       // RQ13
    wire bus_mail2_wr = a_act && a_wr_q && (a_addr == REG_MAIL2)
                        && second_mail_full_n;           // RQ14

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mail1             <= '0;
            mail2             <= '0;
            first_mail_full_n  <= 1'b1;
            second_mail_full_n <= 1'b1;
        end else begin
            if (a_mail_wr)
                mail1 <= port_a_din;
            if (bus_mail2_wr)
                mail2 <= FW'(hwdata);
            // new mail wins over a same-cycle read
            if (a_mail_wr)
                first_mail_full_n <= 1'b0;
            else if (b_mail_rd)
                first_mail_full_n <= 1'b1;               // RQ13
            if (bus_mail2_wr)
                second_mail_full_n <= 1'b0;
            else if (a_mail_rd)
                second_mail_full_n <= 1'b1;              // RQ14
        end
    end

    // ----------------------------------------
    // port outputs
    // ----------------------------------------
    wire [FW-1:0] next_port_a_bus = port_a_mail_sel ? mail2
                                                    : fifo2_dout; // RQ10
    wire [FW-1:0] b_word = port_b_mail_sel ? mail1
                                           : f1_out_data;  // RQ12
    wire next_port_b_valid = port_b_mail_sel ? !first_mail_full_n
                                             : f1_out_valid;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_a_bus      <= '0;
            port_b_bus      <= '0;
            port_b_valid    <= 1'b0;
            port_a_wr_ready <= 1'b0;
            fifo2_take      <= 1'b0;
        end else begin
            port_a_bus      <= next_port_a_bus;
            port_b_bus      <= b_word[17:0];
            port_b_valid    <= next_port_b_valid;
            port_a_wr_ready <= f1_in_ready && !loop_act;
            fifo2_take      <= f2_take;
        end
    end

    // ----------------------------------------
    // ahb-lite slave, zero wait states
    // ----------------------------------------
    assign status = '{ser_count:       ser_count,
                      method:          method,
                      loop_act:        loop_act,
                      fifo1_in_ready:  f1_in_ready,
                      fifo1_out_valid: f1_out_valid,
                      second_full_n:   second_mail_full_n,
                      first_full_n:    first_mail_full_n};
    wire addr_take = hsel && htrans[1] && hready;
    wire ctrl_wr = a_act && a_wr_q && (a_addr == REG_CTRL);
    logic [31:0] rd_mux;
    always_comb begin
        unique case (haddr[7:0])
            REG_CTRL:   rd_mux = 32'(loop_n);
            REG_STATUS: rd_mux = 32'(status);
            REG_MAIL2:  rd_mux = 32'(mail2);
            REG_MAIL1:  rd_mux = 32'(mail1);
            REG_F1_SEC: rd_mux = ofs_word(f1_sec);
            REG_F1_FST: rd_mux = ofs_word(f1_fst);
            REG_F2_SEC: rd_mux = ofs_word(f2_sec);
            REG_F2_FST: rd_mux = ofs_word(f2_fst);
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            a_act     <= 1'b0;
            a_wr_q    <= 1'b0;
            a_addr    <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            loop_n    <= CTRL_LOOP_N_RST;
        end else begin
            a_act  <= addr_take;
            a_wr_q <= hwrite;
            a_addr <= haddr[7:0];
            if (addr_take && !hwrite)
                hrdata <= (haddr[31:8] == '0) ? rd_mux : '0;
            if (ctrl_wr)
                loop_n <= hwdata[CTRL_LOOP_N_BIT];       // RQ8
        end
    end
endmodule

// ===== test/fml_top_assertions.sv
// concurrent checks on the fml_top ports
`timescale 1ns/10ps
module fml_top_chk
    import fml_pkg::*;
#(
    parameter int FW = FIFO_W_DEF
) (
    // clock, reset, bus answer
    input wire logic          ref_clk,
    input wire logic          rst,
    input wire logic          hreadyout,
    input wire logic          hresp,
    // port a and fifo2 register
    input wire logic          port_a_access_en,
    input wire logic          port_a_mail_sel,
    input wire logic          port_a_wr,
    input wire logic          port_a_rd,
    input wire logic [FW-1:0] port_a_bus,
    input wire logic          fifo2_valid,
    input wire logic [FW-1:0] fifo2_dout,
    input wire logic          fifo2_take,
    // port b and flags
    input wire logic          port_b_rd,
    input wire logic          port_b_mail_sel,
    input wire logic          port_b_valid,
    input wire logic          first_mail_full_n,
    input wire logic          second_mail_full_n
);
    wire a_mrd = port_a_rd & port_a_access_en & port_a_mail_sel;
    wire a_mwr = port_a_wr & port_a_access_en & port_a_mail_sel;
    wire b_mrd = port_b_rd & port_b_mail_sel;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    a_mail2_clear: assert property (a_mrd |=> second_mail_full_n)
        else $error("mail2 flag not emptied by port a read");
    a_mail2_hold: assert property (!second_mail_full_n && !a_mrd |=>
        !second_mail_full_n) else $error("mail2 flag lost without read");
    a_mail1_set: assert property (a_mwr && first_mail_full_n |=>
        !first_mail_full_n) else $error("mail1 flag not set by write");
    a_mail1_clear: assert property (b_mrd && !a_mwr |=>
        first_mail_full_n) else $error("mail1 flag not emptied by read");
    a_mail1_hold: assert property (!first_mail_full_n && !b_mrd |=>
        !first_mail_full_n) else $error("mail1 flag lost without read");
    a_port_a_fifo2: assert property (port_a_rd && port_a_access_en &&
        !port_a_mail_sel |=> port_a_bus == $past(fifo2_dout))
        else $error("port a bus not fifo2 word");
    a_take_valid: assert property (fifo2_take |->
        $past(fifo2_valid)) else $error("fifo2 word taken while not valid");
    a_take_once: assert property (fifo2_take |=> !fifo2_take)
        else $error("fifo2 word taken twice");
    a_b_valid_mail: assert property ($past(port_b_mail_sel) &&
        port_b_mail_sel && $stable(first_mail_full_n) |->
        port_b_valid == !first_mail_full_n)
        else $error("port b valid disagrees with mail1 flag");
endmodule
bind fml_top fml_top_chk #(.FW(FW)) fml_top_chk_inst (.ref_clk, .rst,
    .hreadyout, .hresp, .port_a_access_en, .port_a_mail_sel, .port_a_wr,
    .port_a_rd, .port_a_bus, .fifo2_valid, .fifo2_dout, .fifo2_take,
    .port_b_rd, .port_b_mail_sel, .port_b_valid, .first_mail_full_n,
    .second_mail_full_n);

// ===== test/fml_fifo2_model.sv
// stand-in for the fifo2 output register feeding port a and loopback
`timescale 1ns/10ps
module fml_fifo2_model #(
    parameter int STALL = 1
) (
    // clock and reset
    input  wire logic   ref_clk,
    input  wire logic   rst,
    // output register side
    input  wire logic   fifo2_take,
    output logic        fifo2_valid,
    output logic [35:0] fifo2_dout
);
    logic [35:0] q[$];
    int          gap = 0;
    task automatic push(input logic [35:0] w);
        q.push_back(w);
    endtask
    // slow answer: stays empty a while after each take
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fifo2_valid <= 1'b0;
            fifo2_dout  <= 36'h0;
            gap = 0;
        end else begin
            if (fifo2_take && q.size() > 0) begin
                void'(q.pop_front());
                gap = STALL;
            end else if (gap > 0) begin
                gap--;
            end
            fifo2_valid <= (gap == 0) && (q.size() > 0);
            // no word: data flips every cycle, never a stale copy
            fifo2_dout  <= (gap == 0 && q.size() > 0) ? q[0] : ~fifo2_dout;
        end
    end
endmodule

// ===== test/tb_fml_top.sv
// self-checking bench for mailboxes, loopback, serial load and buffer
`timescale 1ns/10ps
module tb_fml_top;
    import fml_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, hready;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 0;
    logic        hreadyout, hresp, port_a_wr_ready, fifo2_valid, fifo2_take;
    logic        offset_sel0_serial_din = 1, offset_sel1_serial_en_n = 0;
    logic        offset_sel_bit2 = 1, port_a_access_en = 0;
    logic        port_a_mail_sel = 0, port_a_wr = 0, port_a_rd = 0;
    logic [35:0] port_a_din = 0, port_a_bus, fifo2_dout;
    logic        port_b_rd = 0, port_b_mail_sel = 0, port_b_valid;
    logic [17:0] port_b_bus;
    logic        first_mail_full_n, second_mail_full_n;
    int          bad_count = 0, n_tests = 0, acc = 0, t;
    localparam logic [45:0] PAT = {44'h9a5c3f01e2d, 2'b11};
    assign hready = hreadyout;
    always #5 ref_clk = ~ref_clk;
    fml_top fml_top_inst (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
        .offset_sel0_serial_din, .offset_sel1_serial_en_n, .offset_sel_bit2,
        .port_a_access_en, .port_a_mail_sel, .port_a_wr, .port_a_din,
        .port_a_wr_ready, .port_a_rd, .port_a_bus, .fifo2_valid, .fifo2_dout,
        .fifo2_take, .port_b_rd, .port_b_mail_sel, .port_b_bus, .port_b_valid,
        .first_mail_full_n, .second_mail_full_n);
    fml_fifo2_model fml_fifo2_model_inst (.ref_clk, .rst, .fifo2_take,
        .fifo2_valid, .fifo2_dout);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [43:0] got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input [31:0] d);
        @(posedge ref_clk);
        hsel <= 1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic pa(input logic w, rd, ms, input logic [35:0] d);
        @(posedge ref_clk);
        port_a_access_en <= 1;
        port_a_mail_sel <= ms;
        port_a_wr <= w;
        port_a_rd <= rd;
        port_a_din <= d;
        @(posedge ref_clk);
        port_a_wr <= 0;
        port_a_rd <= 0;
        @(negedge ref_clk);
    endtask
    task automatic pb(input logic ms);
        @(posedge ref_clk);
        port_b_rd <= 1;
        port_b_mail_sel <= ms;
        @(posedge ref_clk);
        port_b_rd <= 0;
        @(negedge ref_clk);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #50000;
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 0;
        @(posedge ref_clk);
        offset_sel1_serial_en_n <= 1;
        // 46 enabled bits, two surplus, din flipped while disabled
        for (int i = 45; i >= 0; i--) begin
            @(posedge ref_clk);
            offset_sel0_serial_din <= PAT[i];
            offset_sel1_serial_en_n <= 0;
            @(posedge ref_clk);
            offset_sel0_serial_din <= ~PAT[i];
            offset_sel1_serial_en_n <= 1;
        end
        ahb(0, REG_STATUS, 0);
        chk(r, {6'd44, SEL_SERIAL, 5'b01011}, "status");
        ahb(1, REG_F1_SEC, 32'hffffffff);
        for (int k = 0; k < 4; k++) begin
            ahb(0, REG_F1_SEC + 8'(4 * k), 0);
            chk(r, PAT[45 - 11 * k -: 11], "offset reg");
        end
        ahb(1, 8'h40, 32'hffffffff);
        ahb(0, 8'h40, 0);
        chk(r, 0, "unmapped");
        ahb(0, REG_CTRL, 0);
        chk(r, 1, "ctrl reset");
        $display("serial load test done");
        ahb(1, REG_MAIL2, 32'h0002a5c3);
        ahb(1, REG_MAIL2, 32'h00000001);
        @(negedge ref_clk);
        chk(second_mail_full_n, 0, "mail2 flag");
        pa(0, 1, 1, 0);
        chk(port_a_bus, 36'h00002a5c3, "mail2 out");
        chk(second_mail_full_n, 1, "mail2 empty");
        pa(1, 0, 1, 36'h000014321);
        pa(1, 0, 1, 36'h000000007);
        chk(first_mail_full_n, 0, "mail1 flag");
        ahb(0, REG_MAIL1, 0);
        chk(r[17:0], 18'h14321, "mail1 blocked");
        pb(1);
        chk(port_b_bus, 18'h14321, "mail1 out");
        chk(first_mail_full_n, 1, "mail1 empty");
        $display("mailbox test done");
        @(posedge ref_clk);
        port_b_mail_sel <= 0;
        // ready registered at the write edge tells whether the word landed
        repeat (20) begin
            pa(1, 0, 0, 36'h10000a000 + 36'(acc));
            if (port_a_wr_ready === 1'b1) acc++;
        end
        chk(acc, 16, "fifo fill");
        for (int k = 0; k < 16; k++) begin
            chk(port_b_valid, 1, "fifo valid");
            pb(0);
            chk(port_b_bus, 18'h0a000 + 18'(k), "fifo word");
        end
        pb(0);
        chk({port_b_valid, port_a_wr_ready}, 2'b01, "fifo empty");
        $display("buffer test done");
        for (int k = 0; k < 3; k++)
            fml_fifo2_model_inst.push(36'h500000c00 + 36'(k));
        ahb(1, REG_CTRL, 0);
        t = 0;
        while (fml_fifo2_model_inst.q.size() > 0 && t < 100) begin
            @(posedge ref_clk);
            t++;
        end
        @(negedge ref_clk);
        chk(t < 100, 1, "loop drained");
        chk(port_a_wr_ready, 0, "loop blocks port a");
        ahb(0, REG_STATUS, 0);
        chk(r[4:2], 3'b111, "loop status");
        ahb(1, REG_CTRL, 1);
        for (int k = 0; k < 3; k++) begin
            pb(0);
            chk(port_b_bus, 18'h00c00 + 18'(k), "looped word");
        end
        fml_fifo2_model_inst.push(36'h123456789);
        pa(0, 1, 0, 0);
        chk(port_a_bus, 36'h123456789, "fifo2 out");
        chk(fifo2_take, 1, "fifo2 take");
        $display("loopback test done");
        summarize();
    end
endmodule
